// ==== include/fma_params.svh ====
// Constants for the fault monitor aggregation block.
//
// Operation
// - Memory CRC walker runs always, no enable.
// - CRC mismatch drives memory CRC flag low.
// - One memory word consumed per oscillator tick.
// - Writing one clears memory CRC flag.
// - Output GPIO levels sensed and reported back.
// - Access at index FFh or above flags fault.
// - Lower undefined addresses raise no fault.
// - Nonexistent register reads return all zeros.
// - Each monitor owns an active low flag.
// - Status word carries reset, comm, combined flags.
// - Any unmasked detailed flag low drives combined low.
// - Combined clears only after detailed all clear.
// - Masked detailed flag never drives combined.
// - Disabled monitor reports nothing anywhere.
// - GPIO2 is fault pin: output, source fault.
// - Pin active while unmasked non-reset status flag low.
// - Format and polarity bits shape pin level.
// - Format one gives 50% PWM when inactive.
// - Per flag pin mask blocks pin activation.
`ifndef FMA_PARAMS_SVH
`define FMA_PARAMS_SVH

// ============================================================
// Register byte offsets.
`define FMA_OFS_STATUS 32'h0000_0000
`define FMA_OFS_SUPPLY 32'h0000_0004
`define FMA_OFS_CLOCK 32'h0000_0008
`define FMA_OFS_DIGITAL 32'h0000_000C
`define FMA_OFS_ENABLE 32'h0000_0010
`define FMA_OFS_MASK 32'h0000_0014
`define FMA_OFS_PINCFG 32'h0000_0018
`define FMA_OFS_READBACK 32'h0000_001C
`define FMA_OFS_GPIO 32'h0000_0020
`define FMA_OFS_POKE 32'h0000_0024
`define FMA_OFS_PASSES 32'h0000_0028

// ============================================================
// Limits, reset values and timing.
`define FMA_ACC_LIMIT_IDX 30'h0000_00FF
`define FMA_ENABLE_RST 12'hFFF
`define FMA_MASK_RST 12'h000
`define FMA_CRC_SEED 16'hFFFF
`define FMA_CRC_POLY 16'h1021
`define FMA_MEM_SEED 16'hA5C3
`define FMA_MEM_WORDS 16
`define FMA_CLK_PERIOD_NS 4
`define FMA_DIAGNOSTIC_OSCILLATOR_PERIOD_NS 16
`define FMA_DIAGNOSTIC_OSCILLATOR_TICK_CYC (`FMA_DIAGNOSTIC_OSCILLATOR_PERIOD_NS / `FMA_CLK_PERIOD_NS)
`define FMA_PWM_HALF_NS 512
`define FMA_PWM_HALF_CYC (`FMA_PWM_HALF_NS / `FMA_CLK_PERIOD_NS)

`endif

// ==== include/fma_pkg.sv ====
// Types shared by the fault monitor aggregation block.
`default_nettype none
package fma_pkg;
    // Phases of the memory CRC walker.
    typedef enum logic [0:0] {
        FMA_WALK,
        FMA_CHECK
    } fma_walk_e;
endpackage
`default_nettype wire

// ==== logic/fma_fault_monitor.sv ====
// Fault flag aggregation, memory CRC walker and fault pin logic.
//
// The address map and the APB slave port were left to the implementer.
`include "fma_params.svh"
`default_nettype none
module fma_fault_monitor (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] supplyEvt,
    input wire logic [3:0] clockEvt,
    input wire logic [2:0] digitalEvt,
    input wire logic [3:0] commEvt,
    input wire logic [4:0] gpioIn,
    output logic [4:0] gpioOut,
    output logic [4:0] gpioOe,
    output logic [15:0] statusWord
);
    // ============================================================
    // Helper functions.

    // CCITT CRC step over one 16-bit word, MSB first.
    function automatic logic [15:0] crcWord(input logic [15:0] c,
                                            input logic [15:0] d);
        logic fb;
        for (int b = 15; b >= 0; b--) begin
            fb = c[15] ^ d[b];
            c = {c[14:0], 1'b0};
            if (fb) begin
                c = c ^ `FMA_CRC_POLY;
            end
        end
        return c;
    endfunction

    // Production content of memory word i.
    function automatic logic [15:0] memInit(input int i);
        return {i[11:0], 4'h0} ^ `FMA_MEM_SEED;
    endfunction

    // Reference CRC stored in the last word at production.
    function automatic logic [15:0] refCrc();
        logic [15:0] c;
        c = `FMA_CRC_SEED;
        for (int i = 0; i < `FMA_MEM_WORDS - 1; i++) begin
            c = crcWord(c, memInit(i));
        end
        return c;
    endfunction

    // Active-low flag update: enable gate, write-one clear, set wins.
    function automatic logic [3:0] nextFlag(input logic [3:0] cur,
                                            input logic [3:0] evt,
                                            input logic [3:0] en,
                                            input logic [3:0] clr);
        return ~en | ((cur | clr) & ~evt);
    endfunction

    localparam logic [15:0] REF_CRC = refCrc();
    localparam int MW = `FMA_MEM_WORDS;

    // ============================================================
    // Pin synchronisers.

    logic [15:0] syncA; // First stage, read only by syncB.
    logic [15:0] syncB; // Stable copy of the pin levels.

    // Every pin input except commEvt passes two flops before use.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            syncA <= 16'h0000;
            syncB <= 16'h0000;
        end else begin
            syncA <= {gpioIn, digitalEvt, clockEvt, supplyEvt};
            syncB <= syncA;
        end
    end

    wire logic [3:0] supS = syncB[3:0];
    wire logic [3:0] clkS = syncB[7:4];
    wire logic [2:0] digS = syncB[10:8];
    wire logic [4:0] gpiS = syncB[15:11];

    // ============================================================
    // APB slave.

    // Access phase completes on pready; decode is on full address.
    wire logic access = psel & penable & pready;
    wire logic wrEn = access & pwrite;
    // Register index FFh and beyond is outside the register space.
    wire logic outRange = paddr[31:2] >= `FMA_ACC_LIMIT_IDX;

    // Write-one-to-clear strobes per register.
    function automatic logic [3:0] clrOf(input logic [31:0] a,
                                         input logic [31:0] ofs,
                                         input logic [3:0] d,
                                         input logic we);
        return (we && a == ofs) ? d : 4'h0;
    endfunction

    logic [31:0] rdMux; // Read data for the current address.
    logic mapped; // Address hits a defined register other than poke.
    // Configuration and flag registers, declared before the mux.
    logic [3:0] supplyFlag;
    logic [3:0] clockFlag;
    logic [3:0] digitalFlag; // Bit 0 is the memory CRC flag.
    logic [3:0] commFlag;
    logic accessFlag;
    logic [2:0] combFlag; // Supply, clock, digital.
    logic resetFlag;
    logic [11:0] enableReg;
    logic [11:0] maskReg;
    logic [11:0] pinCfg; // Src, fmt, pol, dir-free, pin mask.
    logic [4:0] gpioDir;
    logic [4:0] gpioData;
    logic [15:0] passCount;
    logic [15:0] curStatus;

    // Combined flags sit supply, clock, digital from bit 14 down, so a
    // write-one at a status bit clears the same flag that the bit shows.
    assign curStatus = {resetFlag, combFlag[0], combFlag[1], combFlag[2],
                        accessFlag, commFlag, 7'h00};

    // Read multiplexer; unknown addresses answer zero.
    always_comb begin
        rdMux = 32'h0000_0000;
        mapped = 1'b1;
        case (paddr)
            `FMA_OFS_STATUS: rdMux = {16'h0000, curStatus};
            `FMA_OFS_SUPPLY: rdMux = {28'h0, supplyFlag};
            `FMA_OFS_CLOCK: rdMux = {28'h0, clockFlag};
            `FMA_OFS_DIGITAL: rdMux = {28'h0, digitalFlag};
            `FMA_OFS_ENABLE: rdMux = {20'h0, enableReg};
            `FMA_OFS_MASK: rdMux = {20'h0, maskReg};
            `FMA_OFS_PINCFG: rdMux = {20'h0, pinCfg};
            // Sensed level shown only for pins driven as outputs.
            `FMA_OFS_READBACK: rdMux = {27'h0, gpiS & gpioDir};
            `FMA_OFS_GPIO: rdMux = {22'h0, gpioData, gpioDir};
            `FMA_OFS_PASSES: rdMux = {16'h0000, passCount};
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // No wait state: pready is high in the first access-phase cycle only.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable & ~pready;
            prdata <= rdMux;
        end
    end

    // Configuration registers written by software.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            enableReg <= `FMA_ENABLE_RST;
            maskReg <= `FMA_MASK_RST;
            pinCfg <= 12'h000;
            gpioDir <= 5'h00;
            gpioData <= 5'h00;
        end else if (wrEn) begin
            case (paddr)
                `FMA_OFS_ENABLE: enableReg <= pwdata[11:0];
                `FMA_OFS_MASK: maskReg <= pwdata[11:0];
                `FMA_OFS_PINCFG: pinCfg <= pwdata[11:0];
                `FMA_OFS_GPIO: begin
                    gpioDir <= pwdata[4:0];
                    gpioData <= pwdata[9:5];
                end
                default: begin
                    gpioDir <= gpioDir;
                end
            endcase
        end
    end

    // ============================================================
    // Memory CRC walker.

    logic [15:0] mem [MW]; // Internal memory, last word is reference.
    logic [1:0] oscdCnt;
    logic oscdTick; // One pulse per diagnostic oscillator period.
    logic [3:0] walkIdx;
    logic [15:0] crcAcc;
    logic crcMismatch;
    fma_pkg::fma_walk_e walkState;

    // Diagnostic oscillator period as an enable divider.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            oscdCnt <= 2'h0;
            oscdTick <= 1'b0;
        end else begin
            oscdCnt <= oscdCnt + 2'h1;
            oscdTick <= oscdCnt == 2'(`FMA_DIAGNOSTIC_OSCILLATOR_TICK_CYC - 1);
        end
    end

    // Memory loads production content; poke lets software upset bits.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < MW - 1; i++) begin
                mem[i] <= memInit(i);
            end
            mem[MW-1] <= REF_CRC;
        end else if (wrEn && paddr == `FMA_OFS_POKE) begin
            mem[pwdata[19:16]] <= mem[pwdata[19:16]] ^ pwdata[15:0];
        end
    end

    // Free-running walk with no enable; it restarts after each pass.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            walkState <= fma_pkg::FMA_WALK;
            walkIdx <= 4'h0;
            crcAcc <= `FMA_CRC_SEED;
            crcMismatch <= 1'b0;
            passCount <= 16'h0000;
        end else begin
            crcMismatch <= 1'b0;
            if (oscdTick) begin
                case (walkState)
                    fma_pkg::FMA_WALK: begin
                        crcAcc <= crcWord(crcAcc, mem[walkIdx]);
                        walkIdx <= walkIdx + 4'h1;
                        if (walkIdx == 4'(MW - 2)) begin
                            walkState <= fma_pkg::FMA_CHECK;
                        end
                    end
                    fma_pkg::FMA_CHECK: begin
                        // The reference word is consumed in this tick.
                        crcMismatch <= crcAcc != mem[walkIdx];
                        crcAcc <= `FMA_CRC_SEED;
                        walkIdx <= 4'h0;
                        passCount <= passCount + 16'h0001;
                        walkState <= fma_pkg::FMA_WALK;
                    end
                    default: begin
                        walkState <= fma_pkg::FMA_WALK;
                    end
                endcase
            end
        end
    end

    // ============================================================
    // Detailed flags, combined flags and status word.

    wire logic [3:0] supEn = enableReg[3:0];
    wire logic [3:0] clkEn = enableReg[7:4];
    // The memory CRC monitor has no enable, so bit 0 reads as one.
    wire logic [3:0] digEn = {enableReg[11:9], 1'b1};
    wire logic [3:0] digEvtAll = {digS, crcMismatch};
    wire logic [3:0] statClr = clrOf(paddr, `FMA_OFS_STATUS,
                                     pwdata[15:12], wrEn);
    wire logic [3:0] commClr = clrOf(paddr, `FMA_OFS_STATUS,
                                     pwdata[10:7], wrEn);
    wire logic accClr = wrEn && paddr == `FMA_OFS_STATUS && pwdata[11];

    // Unmasked faults per group; masked ones stay detail-only.
    wire logic [2:0] groupFault = {
        |(~digitalFlag & ~maskReg[11:8]),
        |(~clockFlag & ~maskReg[7:4]),
        |(~supplyFlag & ~maskReg[3:0])};
    wire logic [2:0] groupClean = {&digitalFlag, &clockFlag,
                                   &supplyFlag};

    // Detailed flags: sticky low, gated by enable, cleared by ones.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            supplyFlag <= 4'hF;
            clockFlag <= 4'hF;
            digitalFlag <= 4'hF;
        end else begin
            supplyFlag <= nextFlag(supplyFlag, supS, supEn,
                clrOf(paddr, `FMA_OFS_SUPPLY, pwdata[3:0], wrEn));
            clockFlag <= nextFlag(clockFlag, clkS, clkEn,
                clrOf(paddr, `FMA_OFS_CLOCK, pwdata[3:0], wrEn));
            digitalFlag <= nextFlag(digitalFlag, digEvtAll,
                digEn,
                clrOf(paddr, `FMA_OFS_DIGITAL, pwdata[3:0], wrEn));
        end
    end

    // Combined flags follow groups; clear needs a clean group.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            combFlag <= 3'h7;
        end else begin
            for (int g = 0; g < 3; g++) begin
                if (groupFault[g]) begin
                    combFlag[g] <= 1'b0;
                end else if (statClr[2-g] && groupClean[g]) begin
                    combFlag[g] <= 1'b1;
                end
            end
        end
    end

    // Communication and access flags; reset flag marks a reset.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            commFlag <= 4'hF;
            accessFlag <= 1'b1;
            resetFlag <= 1'b0;
        end else begin
            commFlag <= nextFlag(commFlag, commEvt, 4'hF, commClr);
            // Only index FFh and above counts as illegal.
            if (access && outRange) begin
                accessFlag <= 1'b0;
            end else if (accClr) begin
                accessFlag <= 1'b1;
            end
            if (statClr[3]) begin
                resetFlag <= 1'b1;
            end
        end
    end

    // Word sent at the head of every frame by the serial port.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            statusWord <= 16'h0000;
        end else begin
            statusWord <= curStatus;
        end
    end

    // ============================================================
    // Fault pin on GPIO2 and GPIO drivers.

    wire logic pinSrc = pinCfg[0];
    wire logic pinFmt = pinCfg[1];
    wire logic pinPol = pinCfg[2];
    wire logic [7:0] pinMask = pinCfg[11:4];
    wire logic pinActive = |(~curStatus[14:7] & ~pinMask);
    logic [7:0] pwmCnt;
    logic pwmLevel; // Square wave, half period each level.

    // Heartbeat source: a 50% duty square wave.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pwmCnt <= 8'h00;
            pwmLevel <= 1'b0;
        end else if (pwmCnt == 8'(`FMA_PWM_HALF_CYC - 1)) begin
            pwmCnt <= 8'h00;
            pwmLevel <= ~pwmLevel;
        end else begin
            pwmCnt <= pwmCnt + 8'h01;
        end
    end

    // Active drives the polarity level; inactive is static or PWM.
    wire logic faultLevel = pinActive ? pinPol :
        (pinFmt ? pwmLevel : ~pinPol);

    // Drivers registered so every pin output comes from a flop.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            gpioOut <= 5'h00;
            gpioOe <= 5'h00;
        end else begin
            gpioOe <= gpioDir;
            gpioOut <= gpioData;
            if (gpioDir[2] && !pinSrc) begin
                gpioOut[2] <= faultLevel;
            end
        end
    end

    // ============================================================
    // Assertions.

    property p_memFlag;
        @(posedge core_clk) disable iff (rst)
        crcMismatch |=> !digitalFlag[0];
    endproperty
    a_memFlag: assert property (p_memFlag)
        else $error("memory CRC flag not set on mismatch");

    property p_tickSpacing;
        @(posedge core_clk) disable iff (rst)
        oscdTick |=> !oscdTick [*3] ##1 oscdTick;
    endproperty
    a_tickSpacing: assert property (p_tickSpacing)
        else $error("oscillator tick spacing wrong");

    property p_accFault;
        @(posedge core_clk) disable iff (rst)
        access && outRange |=> !accessFlag;
    endproperty
    a_accFault: assert property (p_accFault)
        else $error("out of range access not flagged");

    property p_accQuiet;
        @(posedge core_clk) disable iff (rst)
        accessFlag && !(access && outRange) |=> accessFlag;
    endproperty
    a_accQuiet: assert property (p_accQuiet)
        else $error("access flag fell without illegal access");

    property p_unmapped;
        @(posedge core_clk) disable iff (rst)
        access && !pwrite && !mapped |-> prdata == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read returned data");

    property p_combSet;
        @(posedge core_clk) disable iff (rst)
        |(~supplyFlag & ~maskReg[3:0]) |=> !combFlag[0];
    endproperty
    a_combSet: assert property (p_combSet)
        else $error("supply combined flag missed a fault");

    property p_combHold;
        @(posedge core_clk) disable iff (rst)
        !combFlag[1] && !(&clockFlag) |=> !combFlag[1];
    endproperty
    a_combHold: assert property (p_combHold)
        else $error("clock combined cleared with detail pending");

    property p_disabled;
        @(posedge core_clk) disable iff (rst)
        &(supplyFlag | $past(supEn));
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("disabled monitor reported a fault");

    property p_status;
        @(posedge core_clk) disable iff (rst)
        1'b1 |=> statusWord == $past(curStatus);
    endproperty
    a_status: assert property (p_status)
        else $error("status word does not follow flags");

    property p_pinStatic;
        @(posedge core_clk) disable iff (rst)
        gpioDir[2] && !pinSrc && !pinFmt && !pinActive
            |=> gpioOut[2] == ~$past(pinPol);
    endproperty
    a_pinStatic: assert property (p_pinStatic)
        else $error("inactive static pin level wrong");

    property p_sticky;
        @(posedge core_clk) disable iff (rst)
        !clockFlag[3] && clkEn[3] && !(wrEn && paddr == `FMA_OFS_CLOCK)
            |=> !clockFlag[3];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("clock flag released without a write");
endmodule
`default_nettype wire

// ==== tb/fma_pin_model.sv ====
// Pin side model: pads with pull-ups and the sensed levels.
`default_nettype none
module fma_pin_model (
    input wire logic [4:0] gpioOut,
    input wire logic [4:0] gpioOe,
    output logic [4:0] gpioIn
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Pad levels.
    // A driven pad shows the drive value; a released pad floats
    // up to the pull-up, so stale drive values never leak back.
    assign gpioIn = (gpioOut & gpioOe) | ~gpioOe;
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the fault monitor aggregation block.
`include "fma_params.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Stimulus, observed outputs and counters.
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, rd, prdata;
    logic pready, pslverr;
    logic [3:0] supplyEvt = 4'h0, clockEvt = 4'h0, commEvt = 4'h0;
    logic [2:0] digitalEvt = 3'h0;
    wire logic [4:0] gpioIn;
    logic [4:0] gpioOut, gpioOe;
    logic [15:0] statusWord;
    int errors = 0;
    int n_tests = 0;
    // ==========================================================
    // Block and pad model.
    fma_fault_monitor dut (.core_clk(core_clk), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .supplyEvt(supplyEvt),
        .clockEvt(clockEvt), .digitalEvt(digitalEvt),
        .commEvt(commEvt), .gpioIn(gpioIn), .gpioOut(gpioOut),
        .gpioOe(gpioOe), .statusWord(statusWord));
    fma_pin_model pads (.gpioOut(gpioOut), .gpioOe(gpioOe),
        .gpioIn(gpioIn));
    // Free running 250 MHz clock.
    initial forever #2 core_clk = ~core_clk;
    // ==========================================================
    // Shared tasks.
    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Compares one value and counts the outcome.
    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] seen);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // One APB transfer; the request holds until pready is seen.
    task automatic bus(input logic w, input logic [31:0] a, d);
        int i;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge core_clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            errors++;
            give_verdict();
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Waits, bounded, for one status bit to fall.
    task automatic wait_low(input int b);
        int i;
        for (i = 0; i < 400 && statusWord[b] !== 1'b0; i++) idle(1);
        if (i == 400) begin
            errors++;
            give_verdict();
        end
    endtask
    // ==========================================================
    // Scenarios.
    task automatic t_reset;
        bus(0, `FMA_OFS_STATUS, 0);
        chk("status", 32'h7F80, rd);
        chk("word", 32'h7F80, statusWord);
        bus(0, `FMA_OFS_ENABLE, 0);
        chk("enable", 32'hFFF, rd);
        bus(1, `FMA_OFS_STATUS, 32'h8000);
        idle(2);
        chk("rstflag", 32'hFF80, statusWord);
        $display("reset test done");
    endtask
    // Low undefined addresses are silent; index FFh and up flag.
    task automatic t_access;
        bus(0, 32'h30, 0);
        chk("unmapped", 0, rd);
        idle(3);
        chk("quiet", 1, statusWord[11]);
        bus(0, 32'h3FC, 0);
        chk("farrd", 0, rd);
        chk("slverr", 0, pslverr);
        idle(3);
        chk("accrd", 0, statusWord[11]);
        bus(1, `FMA_OFS_STATUS, 32'h0800);
        idle(3);
        chk("accclr", 1, statusWord[11]);
        bus(1, 32'h400, 32'h1);
        idle(3);
        chk("accwr", 0, statusWord[11]);
        bus(1, `FMA_OFS_STATUS, 32'h0800);
        $display("access test done");
    endtask
    // Sticky detailed flags feed combined flags; clear order.
    task automatic t_groups;
        supplyEvt <= 4'h1;
        clockEvt <= 4'h8;
        digitalEvt <= 3'h4;
        idle(4);
        supplyEvt <= 4'h0;
        clockEvt <= 4'h0;
        digitalEvt <= 3'h0;
        idle(6);
        chk("comb", 0, statusWord[14:12]);
        bus(1, `FMA_OFS_SUPPLY, 0);
        bus(0, `FMA_OFS_SUPPLY, 0);
        chk("supply", 32'hE, rd);
        bus(0, `FMA_OFS_CLOCK, 0);
        chk("clock", 32'h7, rd);
        bus(0, `FMA_OFS_DIGITAL, 0);
        chk("digital", 32'h7, rd);
        bus(1, `FMA_OFS_STATUS, 32'h7000);
        idle(3);
        chk("early", 0, statusWord[14:12]);
        bus(1, `FMA_OFS_SUPPLY, 32'h1);
        bus(1, `FMA_OFS_CLOCK, 32'h8);
        bus(1, `FMA_OFS_DIGITAL, 32'h8);
        bus(1, `FMA_OFS_STATUS, 32'h7000);
        idle(3);
        chk("cleared", 7, statusWord[14:12]);
        $display("group test done");
    endtask
    // A masked flag latches alone; a disabled one stays quiet.
    task automatic t_mask;
        bus(1, `FMA_OFS_MASK, 32'h2);
        bus(1, `FMA_OFS_ENABLE, 32'hFFB);
        supplyEvt <= 4'h6;
        idle(4);
        supplyEvt <= 4'h0;
        idle(6);
        bus(0, `FMA_OFS_SUPPLY, 0);
        chk("masked", 32'hD, rd);
        chk("nocomb", 1, statusWord[14]);
        bus(1, `FMA_OFS_SUPPLY, 32'h2);
        bus(1, `FMA_OFS_MASK, 0);
        bus(1, `FMA_OFS_ENABLE, 32'hFFF);
        $display("mask test done");
    endtask
    // Driven pads read back; pads not driven read as zero.
    task automatic t_gpio;
        bus(1, `FMA_OFS_PINCFG, 32'h1);
        bus(1, `FMA_OFS_GPIO, 32'h1BF);
        idle(4);
        bus(0, `FMA_OFS_READBACK, 0);
        chk("rball", 32'h0D, rd);
        bus(1, `FMA_OFS_GPIO, 32'h3E3);
        idle(4);
        bus(0, `FMA_OFS_READBACK, 0);
        chk("rbpart", 32'h03, rd);
        $display("gpio test done");
    endtask
    // Fault pin: level, polarity, pin mask and heartbeat.
    task automatic t_pin;
        int highs;
        highs = 0;
        bus(1, `FMA_OFS_GPIO, 32'h4);
        bus(1, `FMA_OFS_PINCFG, 0);
        idle(3);
        chk("oe", 1, gpioOe[2]);
        chk("idle", 1, gpioOut[2]);
        commEvt <= 4'h1;
        idle(2);
        commEvt <= 4'h0;
        idle(3);
        chk("active", 0, gpioOut[2]);
        bus(1, `FMA_OFS_PINCFG, 32'h4);
        idle(2);
        chk("polhigh", 1, gpioOut[2]);
        bus(1, `FMA_OFS_PINCFG, 32'h14);
        idle(2);
        chk("pinmask", 0, gpioOut[2]);
        bus(1, `FMA_OFS_PINCFG, 32'h2);
        bus(1, `FMA_OFS_STATUS, 32'h0080);
        idle(3);
        repeat (512) begin
            @(posedge core_clk);
            highs += (gpioOut[2] === 1'b1);
        end
        chk("pwm", 256, highs);
        bus(1, `FMA_OFS_PINCFG, 0);
        idle(2);
        chk("inactive", 1, gpioOut[2]);
        $display("pin test done");
    endtask
    // The walker runs unasked and catches a corrupted word.
    task automatic t_crc;
        logic [31:0] first;
        bus(0, `FMA_OFS_PASSES, 0);
        first = rd;
        idle(140);
        bus(0, `FMA_OFS_PASSES, 0);
        chk("walking", 1, rd > first);
        bus(1, `FMA_OFS_POKE, 32'h0003_0001);
        wait_low(12);
        bus(0, `FMA_OFS_DIGITAL, 0);
        chk("crcflag", 32'hE, rd);
        bus(1, `FMA_OFS_DIGITAL, 32'h1);
        bus(0, `FMA_OFS_DIGITAL, 0);
        chk("crcclr", 32'hF, rd);
        bus(1, `FMA_OFS_STATUS, 32'h1000);
        idle(3);
        chk("digcomb", 1, statusWord[12]);
        wait_low(12);
        bus(0, `FMA_OFS_DIGITAL, 0);
        chk("again", 32'hE, rd);
        $display("crc test done");
    endtask
    // ==========================================================
    // Main sequence.
    initial begin
        idle(3);
        rst <= 1'b0;
        t_reset();
        t_access();
        t_groups();
        t_mask();
        t_gpio();
        t_pin();
        t_crc();
        give_verdict();
    end
endmodule
`default_nettype wire
